/* logic/trc_regs.svh */
`ifndef TRC_REGS_SVH
`define TRC_REGS_SVH
`define TRC_SLOTS         20
`define TRC_SLOT_MIN      9'h001
`define TRC_SLOT_MAX      9'h014
`define TRC_BUZZ_MAX      9'h003
`define TRC_CCHG_MAX      9'h001
`define TRC_ERR_OVR       2
`define TRC_ERR_FRM       1
`define TRC_ERR_PAR       0
`define TRC_RESP_MAX      300
`define TRC_HDR_LEN       13
`define TRC_NUM_LEN       6
`define TRC_TXT_LEN       3
`define TRC_BUZZ_RST      2'h0
`define TRC_CCHG_RST      1'b0
`define TRC_DEF_CURR      10'h0FA
`define TRC_DEF_MAX       12'h064
`define TRC_DEF_MIN       12'h000
`define TRC_DEF_TIME      14'h0258
`define TRC_DEF_MIN_ON    1'b0
`define TRC_DEF_TIME_ON   1'b1
`define TRC_DEF_UNIT_OHM  1'b1
`endif

/* logic/trc_pkg.sv */
package trc_pkg;
    typedef enum logic [3:0] {
        OP_NONE, OP_MEM_CLEAR, OP_MEM_QUERY, OP_MEM_LOAD, OP_MEM_SAVE, OP_START, OP_STATE_Q, OP_STOP,
        OP_ERR_Q, OP_BUZZ_SET, OP_BUZZ_Q, OP_CCHG_SET, OP_CCHG_Q
    } trc_op_t;

    typedef struct packed {
        trc_op_t    op;
        logic       has_data;
        logic       numeric;
        logic [7:0] int_part;
        logic       frac_half;
    } trc_cmd_t;

    typedef struct packed {
        logic [9:0]  curr;
        logic [11:0] max_val;
        logic [11:0] min_val;
        logic        min_on;
        logic [13:0] time_val;
        logic        time_on;
        logic        unit_ohm;
    } trc_setting_t;

    typedef enum logic [1:0] {SCR_NONE, SCR_SAVE, SCR_LOAD, SCR_OPTION} trc_screen_t;
    typedef enum logic [2:0] {RES_PASS, RES_UPPER_LIMIT_FAIL, RES_LOWER_LIMIT_FAIL, RES_PFAIL, RES_NONE} trc_result_t;
    typedef enum logic [2:0] {
        CODE_PASS, CODE_UPPER_FAIL, CODE_LOWER_FAIL, CODE_PROT_FAIL, CODE_READY, CODE_TEST, CODE_OFF
    } trc_state_code_t;

    typedef enum logic [6:0] {
        US_READY = 7'h01, US_TEST = 7'h02, US_PASS = 7'h04, US_UPPER_LIMIT_FAIL = 7'h08,
        US_LOWER_LIMIT_FAIL = 7'h10, US_PFAIL = 7'h20, US_HOLD = 7'h40
    } trc_unit_t;

    typedef enum logic [1:0] {TAG_NUM, TAG_DASH, TAG_OFF} trc_tag_t;
    typedef enum logic [1:0] {RK_STATE, RK_SLOT, RK_NUM} trc_kind_t;

    typedef struct packed {
        trc_kind_t       kind;
        logic            no_hdr;
        trc_state_code_t code;
        logic [7:0]      num;
        trc_setting_t    slot;
        trc_tag_t        min_tag;
        trc_tag_t        time_tag;
    } trc_resp_t;
endpackage : trc_pkg

/* logic/trc_slot_mem.sv */
`timescale 1ns/1ps
module trc_slot_mem #(
    parameter int DEPTH = 20,
    parameter int AW    = 5
) (
    input  wire logic                  clk_i,
    input  wire logic                  we_i,
    input  wire logic [AW-1:0]         waddr_i,
    input  wire trc_pkg::trc_setting_t wdata_i,
    input  wire logic [AW-1:0]         raddr_i,
    output trc_pkg::trc_setting_t      rdata_o
);
    import trc_pkg::*;

    generate
        if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
            $error("trc_slot_mem: DEPTH does not fit AW");
        end
    endgenerate

    trc_setting_t mem [DEPTH];

    // Slots hold no reset value; power-up content is whatever software saves or clears
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule : trc_slot_mem

/* logic/trc_param_round.sv */
`timescale 1ns/1ps
module trc_param_round (
    input  wire logic       numeric_i,
    input  wire logic [7:0] int_i,
    input  wire logic       frac_half_i,
    input  wire logic [8:0] lo_i,
    input  wire logic [8:0] hi_i,
    output logic [8:0]      value_o,
    output logic            ok_o
);
    // Rounding widens by one bit so 255.5 cannot wrap into range
    always_comb begin
        value_o = {1'b0, int_i} + {8'h00, frac_half_i};
        ok_o    = numeric_i && (value_o >= lo_i) && (value_o <= hi_i);
    end
endmodule : trc_param_round

/* logic/trc_core.sv */
`timescale 1ns/1ps
`include "trc_regs.svh"
module trc_core (
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic                   cmd_valid_i,
    input  wire trc_pkg::trc_cmd_t      cmd_i,
    input  wire logic                   hdr_en_i,
    input  wire trc_pkg::trc_screen_t   screen_i,
    input  wire logic                   lower_fn_i,
    input  wire logic                   endless_fn_i,
    input  wire logic                   hold_fn_i,
    input  wire trc_pkg::trc_setting_t  cur_set_i,
    input  wire logic                   test_end_i,
    input  wire trc_pkg::trc_result_t   result_i,
    input  wire logic                   overrun_i,
    input  wire logic                   framing_i,
    input  wire logic                   parity_i,
    output logic                        resp_valid_o,
    output trc_pkg::trc_resp_t          resp_o,
    output logic                        exec_err_o,
    output logic                        cmd_err_o,
    output logic                        query_err_o,
    output trc_pkg::trc_unit_t          unit_state_o,
    output logic                        test_start_o,
    output logic                        test_stop_o,
    output logic                        momentary_dis_o,
    output logic                        load_o,
    output trc_pkg::trc_setting_t       settings_o,
    output logic [1:0]                  buzzer_o,
    output logic                        live_current_adjust_o,
    output logic [7:0]                  serial_link_error_flags_o
);
    import trc_pkg::*;

    typedef enum logic [1:0] {FS_IDLE = 2'b01, FS_READ = 2'b10} trc_fsm_t;

    typedef struct packed {
        trc_fsm_t     fsm;
        trc_op_t      pend_op;
        trc_unit_t    unit;
        logic [2:0]   err;
        logic [1:0]   buzz;
        logic         cchg;
        logic         mom_dis;
        logic         resp_valid;
        trc_resp_t    resp;
        logic         exec_err;
        logic         cmd_err;
        logic         qry_err;
        logic         start;
        logic         stop;
        logic         load;
        trc_setting_t settings;
    } trc_state_t;

    localparam trc_setting_t DEF_SET = '{
        curr: `TRC_DEF_CURR, max_val: `TRC_DEF_MAX, min_val: `TRC_DEF_MIN, min_on: `TRC_DEF_MIN_ON,
        time_val: `TRC_DEF_TIME, time_on: `TRC_DEF_TIME_ON, unit_ohm: `TRC_DEF_UNIT_OHM};

    function automatic logic [8:0] op_hi(input trc_op_t op);
        unique case (op)
            OP_BUZZ_SET: op_hi = `TRC_BUZZ_MAX;
            OP_CCHG_SET: op_hi = `TRC_CCHG_MAX;
            default:     op_hi = `TRC_SLOT_MAX;
        endcase
    endfunction : op_hi

    function automatic logic [8:0] tag_len(input trc_tag_t t);
        tag_len = (t == TAG_NUM) ? 9'(`TRC_NUM_LEN) : 9'(`TRC_TXT_LEN);
    endfunction : tag_len

    trc_state_t   q, d;
    logic [8:0]   pval;
    logic         pok;
    logic         mem_we;
    logic [4:0]   mem_waddr;
    trc_setting_t mem_wdata;
    logic [4:0]   mem_raddr;
    trc_setting_t mem_rdata;
    logic         is_ready;
    logic         set_ok_state;
    logic [8:0]   resp_len;
    logic [2:0]   err_evt;
    trc_state_code_t code;

    trc_param_round u_round (
        .numeric_i   (cmd_i.numeric),
        .int_i       (cmd_i.int_part),
        .frac_half_i (cmd_i.frac_half),
        .lo_i        ((cmd_i.op == OP_BUZZ_SET || cmd_i.op == OP_CCHG_SET) ? 9'h000 : `TRC_SLOT_MIN),
        .hi_i        (op_hi(cmd_i.op)),
        .value_o     (pval),
        .ok_o        (pok)
    );

    trc_slot_mem #(.DEPTH(`TRC_SLOTS), .AW(5)) u_mem (
        .clk_i   (clk_i),
        .we_i    (mem_we),
        .waddr_i (mem_waddr),
        .wdata_i (mem_wdata),
        .raddr_i (mem_raddr),
        .rdata_o (mem_rdata)
    );

    always_comb begin
        d            = q;
        d.resp_valid = 1'b0;
        d.exec_err   = 1'b0;
        d.cmd_err    = 1'b0;
        d.qry_err    = 1'b0;
        d.start      = 1'b0;
        d.stop       = 1'b0;
        d.load       = 1'b0;
        mem_we       = 1'b0;
        mem_wdata    = cur_set_i;
        mem_waddr    = 5'(pval - 9'h001);
        mem_raddr    = 5'(pval - 9'h001);
        resp_len     = 9'h000;
        is_ready     = (q.unit == US_READY) && (screen_i == SCR_NONE);
        set_ok_state = (q.unit == US_READY) && (screen_i == SCR_NONE || screen_i == SCR_OPTION);
        err_evt      = 3'h0;
        err_evt[`TRC_ERR_OVR] = overrun_i;
        err_evt[`TRC_ERR_FRM] = framing_i;
        err_evt[`TRC_ERR_PAR] = parity_i;
        d.err = q.err | err_evt;

        // Panel shows OFF on screens and on a hold that has no verdict
        unique case (q.unit)
            US_PASS:  code = CODE_PASS;
            US_UPPER_LIMIT_FAIL: code = CODE_UPPER_FAIL;
            US_LOWER_LIMIT_FAIL: code = CODE_LOWER_FAIL;
            US_PFAIL: code = CODE_PROT_FAIL;
            US_TEST:  code = CODE_TEST;
            US_HOLD:  code = CODE_OFF;
            default:  code = CODE_READY;
        endcase
        if (screen_i != SCR_NONE) begin
            code = CODE_OFF;
        end

        if (test_end_i && q.unit == US_TEST) begin
            d.mom_dis = 1'b0;
            unique case (result_i)
                RES_PASS:  d.unit = US_PASS;
                RES_UPPER_LIMIT_FAIL: d.unit = US_UPPER_LIMIT_FAIL;
                RES_LOWER_LIMIT_FAIL: d.unit = US_LOWER_LIMIT_FAIL;
                RES_PFAIL: d.unit = US_PFAIL;
                default:   d.unit = hold_fn_i ? US_HOLD : US_READY;
            endcase
        end

        unique case (q.fsm)
            FS_IDLE: begin
                if (cmd_valid_i) begin
                    unique case (cmd_i.op)
                        OP_MEM_CLEAR, OP_MEM_QUERY, OP_MEM_LOAD, OP_MEM_SAVE: begin
                            if (!is_ready || !pok) begin
                                d.exec_err = 1'b1;
                            end else if (cmd_i.op == OP_MEM_CLEAR) begin
                                mem_we    = 1'b1;
                                mem_wdata = DEF_SET;
                            end else if (cmd_i.op == OP_MEM_SAVE) begin
                                mem_we = 1'b1;
                            end else begin
                                d.pend_op = cmd_i.op;
                                d.fsm     = FS_READ;
                            end
                        end
                        OP_START: begin
                            if (cmd_i.has_data) begin
                                d.cmd_err = 1'b1;
                            end else if (!is_ready) begin
                                d.exec_err = 1'b1;
                            end else begin
                                d.unit    = US_TEST;
                                d.start   = 1'b1;
                                d.mom_dis = 1'b1;
                            end
                        end
                        OP_STOP: begin
                            if (cmd_i.has_data) begin
                                d.cmd_err = 1'b1;
                            end else begin
                                // Stop aborts screens too; nothing is saved or loaded
                                d.unit    = US_READY;
                                d.stop    = 1'b1;
                                d.mom_dis = 1'b0;
                            end
                        end
                        OP_STATE_Q: begin
                            d.resp_valid  = 1'b1;
                            d.resp.kind   = RK_STATE;
                            d.resp.no_hdr = !hdr_en_i;
                            d.resp.code   = code;
                        end
                        OP_ERR_Q: begin
                            d.resp_valid  = 1'b1;
                            d.resp.kind   = RK_NUM;
                            d.resp.no_hdr = 1'b1;
                            d.resp.num    = {5'h00, q.err};
                            d.err         = err_evt;                        // New events win over the clear
                        end
                        OP_BUZZ_SET, OP_CCHG_SET: begin
                            if (!set_ok_state || !pok) begin
                                d.exec_err = 1'b1;
                            end else if (cmd_i.op == OP_BUZZ_SET) begin
                                d.buzz = pval[1:0];
                            end else begin
                                d.cchg = pval[0];
                            end
                        end
                        OP_BUZZ_Q, OP_CCHG_Q: begin
                            d.resp_valid  = 1'b1;
                            d.resp.kind   = RK_NUM;
                            d.resp.no_hdr = !hdr_en_i;
                            d.resp.num    = (cmd_i.op == OP_BUZZ_Q) ? {6'h00, q.buzz} : {7'h00, q.cchg};
                        end
                        default: begin
                            d.cmd_err = 1'b1;
                        end
                    endcase
                end
            end
            FS_READ: begin
                d.fsm = FS_IDLE;
                if (q.pend_op == OP_MEM_LOAD) begin
                    d.settings = mem_rdata;
                    d.load     = 1'b1;
                end else begin
                    d.resp.kind     = RK_SLOT;
                    d.resp.no_hdr   = !hdr_en_i;
                    d.resp.slot     = mem_rdata;
                    d.resp.min_tag  = !lower_fn_i ? TAG_DASH : (!mem_rdata.min_on ? TAG_OFF : TAG_NUM);
                    d.resp.time_tag = endless_fn_i ? TAG_DASH : (!mem_rdata.time_on ? TAG_OFF : TAG_NUM);
                    resp_len = (hdr_en_i ? 9'(`TRC_HDR_LEN) : 9'h000) + 9'(3 * `TRC_NUM_LEN + 3)
                             + tag_len(d.resp.min_tag) + tag_len(d.resp.time_tag);
                    if (resp_len > 9'(`TRC_RESP_MAX)) begin
                        d.qry_err = 1'b1;
                    end else begin
                        d.resp_valid = 1'b1;
                    end
                end
            end
            default: begin
                d.fsm = FS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q          <= '0;
            q.fsm      <= FS_IDLE;
            q.pend_op  <= OP_NONE;
            q.unit     <= US_READY;
            q.buzz     <= `TRC_BUZZ_RST;
            q.cchg     <= `TRC_CCHG_RST;
            q.settings <= DEF_SET;
        end else begin
            q <= d;
        end
    end

    assign resp_valid_o              = q.resp_valid;
    assign resp_o                    = q.resp;
    assign exec_err_o                = q.exec_err;
    assign cmd_err_o                 = q.cmd_err;
    assign query_err_o               = q.qry_err;
    assign unit_state_o              = q.unit;
    assign test_start_o              = q.start;
    assign test_stop_o               = q.stop;
    assign momentary_dis_o           = q.mom_dis;
    assign load_o                    = q.load;
    assign settings_o                = q.settings;
    assign buzzer_o                  = q.buzz;
    assign live_current_adjust_o     = q.cchg;
    assign serial_link_error_flags_o = {5'h00, q.err};

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_mem_cmd_ok;
        cmd_valid_i && q.fsm == FS_IDLE && is_ready && pok
            && (cmd_i.op == OP_MEM_QUERY);
    endsequence

    property p_clear_defaults;
        cmd_valid_i && q.fsm == FS_IDLE && cmd_i.op == OP_MEM_CLEAR && is_ready && pok
            |-> mem_we && mem_wdata == DEF_SET && mem_waddr == 5'(pval - 9'h001);
    endproperty
    a_clear_defaults: assert property (p_clear_defaults) else $error("slot clear did not write defaults");

    property p_round_buzz;
        cmd_valid_i && q.fsm == FS_IDLE && cmd_i.op == OP_BUZZ_SET && set_ok_state && cmd_i.numeric
            && cmd_i.int_part == 8'h02 && cmd_i.frac_half |=> buzzer_o == 2'h3;
    endproperty
    a_round_buzz: assert property (p_round_buzz) else $error("buzzer code not rounded up");

    property p_mem_not_ready;
        cmd_valid_i && q.fsm == FS_IDLE && !is_ready
            && (cmd_i.op inside {OP_MEM_CLEAR, OP_MEM_SAVE, OP_MEM_LOAD, OP_START})
            && !(cmd_i.op == OP_START && cmd_i.has_data)
            |-> !mem_we ##1 exec_err_o && !test_start_o && !load_o;
    endproperty
    a_mem_not_ready: assert property (p_mem_not_ready) else $error("command ran outside ready state");

    property p_bad_param;
        cmd_valid_i && q.fsm == FS_IDLE && cmd_i.op == OP_CCHG_SET && !pok
            |=> exec_err_o && $stable(live_current_adjust_o);
    endproperty
    a_bad_param: assert property (p_bad_param) else $error("bad parameter changed a setting");

    property p_query_slot;
        s_mem_cmd_ok |-> ##2 (resp_valid_o && resp_o.kind == RK_SLOT) || query_err_o;
    endproperty
    a_query_slot: assert property (p_query_slot) else $error("slot query gave no answer in two cycles");

    property p_start_data;
        cmd_valid_i && q.fsm == FS_IDLE && cmd_i.op inside {OP_START, OP_STOP} && cmd_i.has_data
            |=> cmd_err_o && !test_start_o && !test_stop_o;
    endproperty
    a_start_data: assert property (p_start_data) else $error("start or stop ran despite data");

    property p_stop_ready;
        cmd_valid_i && q.fsm == FS_IDLE && cmd_i.op == OP_STOP && !cmd_i.has_data
            |=> unit_state_o == US_READY && test_stop_o && !load_o;
    endproperty
    a_stop_ready: assert property (p_stop_ready) else $error("stop did not return to ready");

    property p_err_query;
        cmd_valid_i && q.fsm == FS_IDLE && cmd_i.op == OP_ERR_Q && !overrun_i && !framing_i && !parity_i
            |=> resp_valid_o && resp_o.no_hdr && resp_o.num == $past(serial_link_error_flags_o)
                && serial_link_error_flags_o == 8'h00;
    endproperty
    a_err_query: assert property (p_err_query) else $error("error query value, header or clear wrong");

    property p_start_momentary;
        cmd_valid_i && q.fsm == FS_IDLE && cmd_i.op == OP_START && !cmd_i.has_data && is_ready
            |=> unit_state_o == US_TEST && momentary_dis_o && test_start_o;
    endproperty
    a_start_momentary: assert property (p_start_momentary) else $error("remote start wrong");
endmodule : trc_core

/* bench/trc_host.sv */
`timescale 1ns/1ps
module trc_host (
    input  wire logic         clk_i,
    output logic              cmd_valid_o,
    output trc_pkg::trc_cmd_t cmd_o
);
    import trc_pkg::*;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o       = '0;
    end
    // One command per two cycles stays clear of the gap after a slot read
    task automatic send(input trc_op_t op, input logic dat, input logic num, input logic [7:0] v, input logic fr);
        @(posedge clk_i);
        #1;
        cmd_valid_o = 1'b1;
        cmd_o       = '{op, dat, num, v, fr};
        @(posedge clk_i);
        #1;
        cmd_valid_o = 1'b0;
        // Released fields must not keep showing the old command
        cmd_o       = ~cmd_o;
    endtask : send
endmodule : trc_host

/* bench/tb_top.sv */
`timescale 1ns/1ps
`include "trc_regs.svh"
module tb_top;
    import trc_pkg::*;
    localparam logic [6:0] QE = 7'h40, E = 7'h20, C = 7'h10, R = 7'h08, S = 7'h04, P = 7'h02, L = 7'h01;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, cmd_valid_i, hdr_en_i, lower_fn_i, endless_fn_i, hold_fn_i;
    logic test_end_i, overrun_i, framing_i, parity_i, resp_valid_o, exec_err_o, cmd_err_o, query_err_o;
    logic test_start_o, test_stop_o, momentary_dis_o, load_o, live_current_adjust_o;
    logic [1:0] buzzer_o;
    logic [7:0] serial_link_error_flags_o;
    logic [6:0] seen;
    trc_cmd_t cmd_i;
    trc_screen_t screen_i;
    trc_setting_t cur_set_i, settings_o;
    trc_result_t result_i;
    trc_resp_t resp_o, r_q;
    trc_unit_t unit_state_o;
    int fails = 0, n_tests = 0, cyc = 0;
    trc_setting_t a_set = '{10'h123, 12'h456, 12'h789, 1'b0, 14'h0ABC, 1'b0, 1'b0};
    trc_setting_t dflt = '{`TRC_DEF_CURR, `TRC_DEF_MAX, `TRC_DEF_MIN, `TRC_DEF_MIN_ON, `TRC_DEF_TIME,
                          `TRC_DEF_TIME_ON, `TRC_DEF_UNIT_OHM};
    trc_unit_t ux [5] = '{US_PASS, US_UPPER_LIMIT_FAIL, US_LOWER_LIMIT_FAIL, US_PFAIL, US_HOLD};
    trc_state_code_t cx [5] = '{CODE_PASS, CODE_UPPER_FAIL, CODE_LOWER_FAIL, CODE_PROT_FAIL, CODE_OFF};

    always #20 clk_i = ~clk_i;
    trc_host trc_host_inst (.clk_i, .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));
    trc_core trc_core_inst (.clk_i, .sys_rst_i, .cmd_valid_i, .cmd_i, .hdr_en_i, .screen_i, .lower_fn_i,
        .endless_fn_i, .hold_fn_i, .cur_set_i, .test_end_i, .result_i, .overrun_i, .framing_i, .parity_i,
        .resp_valid_o, .resp_o, .exec_err_o, .cmd_err_o, .query_err_o, .unit_state_o, .test_start_o,
        .test_stop_o, .momentary_dis_o, .load_o, .settings_o, .buzzer_o, .live_current_adjust_o,
        .serial_link_error_flags_o);

    // Pulses are one cycle wide, so collect them instead of sampling once
    always @(posedge clk_i) begin
        seen <= seen | {query_err_o, exec_err_o, cmd_err_o, resp_valid_o, test_start_o, test_stop_o, load_o};
        if (resp_valid_o) r_q <= resp_o;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            close_out();
        end
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic run(input trc_op_t op, input logic dat, input logic [7:0] v, input logic [6:0] exp,
                       input logic fr = 1'b0, input logic num = 1'b1);
        seen = '0;
        trc_host_inst.send(op, dat, num, v, fr);
        repeat (3) @(posedge clk_i);
        #1;
        check(seen, exp);
    endtask : run

    task automatic pulse(ref logic sig);
        @(posedge clk_i);
        #1 sig = 1'b1;
        @(posedge clk_i);
        #1 sig = 1'b0;
    endtask : pulse

    task automatic close_out();
        $display("checks %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    initial begin
        {hdr_en_i, lower_fn_i, endless_fn_i, hold_fn_i} = 4'hB;
        {test_end_i, overrun_i, framing_i, parity_i} = 4'h0;
        screen_i = SCR_NONE;
        cur_set_i = a_set;
        result_i = RES_NONE;
        repeat (10) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        check(unit_state_o, US_READY);
        check(settings_o, dflt);
        check({buzzer_o, live_current_adjust_o, serial_link_error_flags_o}, '0);
        fork pulse(overrun_i); pulse(parity_i); join
        check(serial_link_error_flags_o, 8'h05);
        run(OP_ERR_Q, 0, 0, R);
        check({r_q.no_hdr, r_q.num, serial_link_error_flags_o}, 17'h10500);
        pulse(framing_i);
        run(OP_ERR_Q, 0, 0, R);
        check(r_q.num, 8'h02);
        for (int i = 0; i < 4; i++) begin
            run(OP_BUZZ_SET, 1, i[7:0], 0);
            check(buzzer_o, i[1:0]);
        end
        run(OP_BUZZ_SET, 1, 8'h04, E);
        run(OP_BUZZ_SET, 1, 8'h00, E, 0, 0);
        run(OP_BUZZ_SET, 1, 8'h02, 0, 1);
        run(OP_BUZZ_Q, 0, 0, R);
        check(r_q.num, 8'h03);
        run(OP_CCHG_SET, 1, 8'h01, 0);
        run(OP_CCHG_SET, 1, 8'h02, E);
        run(OP_CCHG_Q, 0, 0, R);
        check({r_q.num, live_current_adjust_o}, 9'h003);
        run(OP_MEM_SAVE, 1, 8'h14, 0);
        run(OP_MEM_LOAD, 1, 8'h14, L);
        check(settings_o, a_set);
        run(OP_MEM_QUERY, 1, 8'h13, R, 1);
        check({r_q.kind, r_q.slot}, {RK_SLOT, a_set});
        check({r_q.min_tag, r_q.time_tag}, {TAG_DASH, TAG_DASH});
        {lower_fn_i, endless_fn_i} = 2'h2;
        run(OP_MEM_QUERY, 1, 8'h14, R);
        check({r_q.min_tag, r_q.time_tag}, {TAG_OFF, TAG_OFF});
        run(OP_MEM_CLEAR, 1, 8'h14, 0);
        run(OP_MEM_QUERY, 1, 8'h14, R);
        check({r_q.slot, r_q.time_tag}, {dflt, TAG_NUM});
        run(OP_MEM_LOAD, 1, 8'h00, E);
        run(OP_MEM_LOAD, 1, 8'h15, E);
        check(settings_o, a_set);
        run(OP_STATE_Q, 0, 0, R);
        check({r_q.no_hdr, r_q.code}, {1'b0, CODE_READY});
        run(OP_START, 1, 0, C);
        run(OP_STOP, 1, 0, C);
        for (int r = 0; r < 5; r++) begin
            run(OP_START, 0, 0, S);
            check({momentary_dis_o, unit_state_o}, {1'b1, US_TEST});
            run(OP_STATE_Q, 0, 0, R);
            check(r_q.code, CODE_TEST);
            run(OP_MEM_SAVE, 1, 8'h01, E);
            run(OP_BUZZ_SET, 1, 8'h00, E);
            result_i = trc_result_t'(r);
            pulse(test_end_i);
            check({momentary_dis_o, unit_state_o}, {1'b0, ux[r]});
            run(OP_STATE_Q, 0, 0, R);
            check(r_q.code, cx[r]);
            run(OP_START, 0, 0, E);
            run(OP_STOP, 0, 0, P);
            check(unit_state_o, US_READY);
        end
        run(OP_START, 0, 0, S);
        run(OP_STOP, 0, 0, P);
        check(unit_state_o, US_READY);
        for (int s = 1; s < 4; s++) begin
            screen_i = trc_screen_t'(s);
            run(OP_STATE_Q, 0, 0, R);
            check(r_q.code, CODE_OFF);
            run(OP_START, 0, 0, E);
            run(OP_BUZZ_SET, 1, 8'h01, (s == 3) ? 7'h00 : E);
            run(OP_STOP, 0, 0, P);
        end
        run(OP_MEM_CLEAR, 1, 8'h01, E);
        check({buzzer_o, unit_state_o, settings_o}, {2'h1, US_READY, a_set});
        close_out();
    end
endmodule : tb_top
